// [bench/mrs_master.sv]
`timescale 1ns/100ps
`include "mrs_defines.vh"
// Serial master: sends RTU frames 8N1, collects reply bytes
module mrs_master #(
    parameter int BIT = `MRS_BIT_CYCLES  // Clocks per bit
) (
    // Clock
    input  wire clk_i,
    // Line to the slave and back
    output reg  line_o,
    input  wire line_i
);
    byte unsigned rsp[$];  // Reply bytes in arrival order
    logic [7:0]   rx_d;    // Byte being received
    // Frame check, low byte sent first
    function automatic logic [15:0] crc16(input byte unsigned b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
            end
        end
        return c;
    endfunction
    // One character, lsb first, BIT clocks per bit
    task automatic send_byte(input logic [7:0] d);
        line_o = 1'b0;
        repeat (BIT) @(negedge clk_i);
        for (int k = 0; k < 8; k++) begin
            line_o = d[k];
            repeat (BIT) @(negedge clk_i);
        end
        line_o = 1'b1;
        repeat (BIT) @(negedge clk_i);
    endtask
    // Whole RTU frame, back to back; bad flips one check bit
    task automatic send(input byte unsigned f[$], input bit bad);
        logic [15:0] c;
        c = crc16(f) ^ (bad ? 16'h0001 : 16'h0000);
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            send_byte(f[i]);
        end
    endtask
    // Idle mark level until the first frame
    initial begin
        line_o = 1'b1;
    end
    // Receive replies, sampled mid bit
    always begin
        @(negedge line_i);
        repeat (BIT + BIT / 2) @(posedge clk_i);
        for (int k = 0; k < 8; k++) begin
            rx_d[k] = line_i;
            repeat (BIT) @(posedge clk_i);
        end
        rsp.push_back(rx_d);
    end
endmodule

// [bench/mrs_slave_sva.sv]
`timescale 1ns/100ps
`include "mrs_defines.vh"
// Pin-level watch on the slave: silence, framing and line timing
module mrs_slave_sva #(
    parameter BIT_CYCLES = `MRS_BIT_CYCLES,
    parameter GAP_CYCLES = `MRS_GAP_CYCLES
) (
    // Clock and reset
    input wire        clk_i,
    input wire        resetn_i,
    // Serial line
    input wire        rx_i,
    input wire        tx_o,
    // Parameter store port
    input wire [15:0] par_addr_o,
    input wire [15:0] par_wdata_o,
    input wire        par_wr_o,
    input wire [15:0] par_rdata_i,
    input wire        par_wide_i,
    input wire        par_err_i,
    // Status
    input wire        frame_drop_o
);
    localparam int BIT = BIT_CYCLES;
    reg [31:0] idle_r;  // Cycles of rx silence, saturating
    reg [31:0] low_r;   // Length of current tx low run
    // Raw line counts; the slave sees rx a few cycles later, so >= is safe
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            idle_r <= 32'h0000_0000;
            low_r  <= 32'h0000_0000;
        end else begin
            idle_r <= !rx_i ? 32'h0000_0000 : idle_r + (idle_r != 32'hFFFF_FFFF);
            low_r  <= tx_o ? 32'h0000_0000 : low_r + 32'h0000_0001;
        end
    end
    a_tx_after_gap: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (idle_r < GAP_CYCLES) |-> tx_o) else $error("reply began before frame end");
    a_wr_after_gap: assert property (@(posedge clk_i) disable iff (!resetn_i)
        par_wr_o |-> (idle_r >= GAP_CYCLES)) else $error("write before frame end");
    a_wr_before_reply: assert property (@(posedge clk_i) disable iff (!resetn_i)
        par_wr_o |-> tx_o && $past(tx_o)) else $error("write during reply");
    a_drop_after_gap: assert property (@(posedge clk_i) disable iff (!resetn_i)
        frame_drop_o |-> (idle_r >= GAP_CYCLES)) else $error("drop before frame end");
    a_drop_silent: assert property (@(posedge clk_i) disable iff (!resetn_i)
        frame_drop_o |-> !par_wr_o ##1 tx_o [*8]) else $error("dropped frame answered");
    a_reset_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> tx_o && !par_wr_o && !frame_drop_o) else $error("not idle");
    a_tx_bit_time: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(tx_o) |-> (low_r % BIT == 0)) else $error("tx low run off bit grid");
    a_tx_low_run: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !tx_o |-> (low_r < 9 * BIT)) else $error("tx low run too long");
endmodule

bind mrs_slave mrs_slave_sva #(.BIT_CYCLES(BIT_CYCLES), .GAP_CYCLES(GAP_CYCLES)) i_mrs_slave_sva (
    .clk_i(clk_i), .resetn_i(resetn_i), .rx_i(rx_i), .tx_o(tx_o),
    .par_addr_o(par_addr_o), .par_wdata_o(par_wdata_o), .par_wr_o(par_wr_o),
    .par_rdata_i(par_rdata_i), .par_wide_i(par_wide_i), .par_err_i(par_err_i),
    .frame_drop_o(frame_drop_o));

// [bench/test_modbus_rtu_slave_command_handler.sv]
`timescale 1ns/100ps
`include "mrs_defines.vh"
// Drives request frames at the slave and judges replies and store writes
module test_modbus_rtu_slave_command_handler;
    localparam int BIT   = 16;               // Short bit period keeps the run brief
    localparam int GAP   = 14 * BIT;         // Shortened silence, still above a character
    localparam int WAIT  = GAP + 400 * BIT;  // Bound on one reply
    localparam int LIMIT = 5000 * BIT;       // Whole run is near 3000 bit times
    reg         clk_i;
    reg         resetn_i;
    wire        rx_i;
    wire        tx_o;
    wire [15:0] par_addr_o;
    wire [15:0] par_wdata_o;
    wire        par_wr_o;
    wire        frame_drop_o;
    int         n_fail;
    int         samples_checked;
    int         n_wr;
    int         n_drop;
    int         cyc;
    logic [15:0] last_addr;
    logic [15:0] last_data;
    // Store model: fixed pattern, one wide and one failing slot
    wire [15:0] par_rdata_i = par_addr_o ^ 16'h5A00;
    wire        par_wide_i  = (par_addr_o == 16'h0040);
    wire        par_err_i   = (par_addr_o == 16'h0050);
    mrs_slave #(.BIT_CYCLES(BIT), .GAP_CYCLES(GAP)) i_mrs_slave (
        .clk_i(clk_i), .resetn_i(resetn_i), .rx_i(rx_i), .tx_o(tx_o),
        .par_addr_o(par_addr_o), .par_wdata_o(par_wdata_o), .par_wr_o(par_wr_o),
        .par_rdata_i(par_rdata_i), .par_wide_i(par_wide_i), .par_err_i(par_err_i),
        .frame_drop_o(frame_drop_o));
    mrs_master #(.BIT(BIT)) i_mrs_master (.clk_i(clk_i), .line_o(rx_i), .line_i(tx_o));
    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Store writes, drop pulses and the hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (par_wr_o === 1'b1) begin
            n_wr      <= n_wr + 1;
            last_addr <= par_addr_o;
            last_data <= par_wdata_o;
        end
        if (frame_drop_o === 1'b1) begin
            n_drop <= n_drop + 1;
        end
        if (cyc == LIMIT) begin
            n_fail = n_fail + 1;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Send one request, compare the whole reply with its check bytes
    task automatic xact(input byte unsigned req[$], input byte unsigned exp[$]);
        logic [15:0] c;
        int n;
        c = i_mrs_master.crc16(exp);
        exp.push_back(c[7:0]);
        exp.push_back(c[15:8]);
        i_mrs_master.rsp.delete();
        i_mrs_master.send(req, 1'b0);
        n = 0;
        while (i_mrs_master.rsp.size() < exp.size() && n < WAIT) begin
            @(negedge clk_i);
            n++;
        end
        repeat (12 * BIT) @(negedge clk_i); // Room for a stray extra byte
        check("reply length", exp.size(), i_mrs_master.rsp.size());
        foreach (exp[i]) begin
            if (i < i_mrs_master.rsp.size()) begin
                check("reply byte", exp[i], i_mrs_master.rsp[i]);
            end
        end
    endtask
    // Exception reply: node, code with top bit, exception code
    task automatic exc(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] q,
                       input logic [7:0] code);
        xact('{8'h01, fc, a[15:8], a[7:0], q[15:8], q[7:0]}, '{8'h01, fc | 8'h80, code});
    endtask
    task automatic sc_write_single();
        int w0;
        w0 = n_wr;
        xact('{8'h01, 8'h06, 8'h00, 8'h12, 8'hAB, 8'hCD},
             '{8'h01, 8'h06, 8'h00, 8'h12, 8'hAB, 8'hCD});
        check("write count", w0 + 1, n_wr);
        check("write addr", 16'h0012, last_addr);
        check("write data", 16'hABCD, last_data);
    endtask
    task automatic sc_read();
        logic [7:0] fc;
        for (int i = 0; i < 2; i++) begin
            fc = 8'h03 + i[7:0];
            xact('{8'h01, fc, 8'h00, 8'h04, 8'h00, 8'h02},
                 '{8'h01, fc, 8'h04, 8'h5A, 8'h04, 8'h5A, 8'h05});
        end
    endtask
    task automatic sc_exceptions();
        int w0;
        exc(8'h00, 16'h0000, 16'h0001, 8'h01);
        exc(8'h05, 16'h0000, 16'h0001, 8'h01);
        exc(8'h81, 16'h0000, 16'h0001, 8'h01);
        exc(8'h03, 16'h0000, 16'h0000, 8'h03);
        exc(8'h04, 16'h0000, 16'h001F, 8'h03);
        exc(8'h04, 16'h00FF, 16'h0002, 8'h02);
        exc(8'h06, 16'h0100, 16'h1234, 8'h02);
        exc(8'h10, 16'h0020, 16'h0001, 8'h03);
        w0 = n_wr;
        exc(8'h06, 16'h0040, 16'h1234, 8'h04);
        check("wide write skipped", w0, n_wr);
        exc(8'h06, 16'h0050, 16'h1234, 8'h04);
    endtask
    task automatic sc_multi_write();
        int w0;
        w0 = n_wr;
        xact('{8'h01, 8'h10, 8'h00, 8'h20, 8'h00, 8'h02, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44},
             '{8'h01, 8'h10, 8'h00, 8'h20, 8'h00, 8'h02});
        check("write count", w0 + 2, n_wr);
        check("write addr", 16'h0021, last_addr);
        check("write data", 16'h3344, last_data);
    endtask
    // Bad check bytes, then another node's address: both ignored
    task automatic sc_dropped();
        int d0;
        int w0;
        int n;
        for (int i = 0; i < 2; i++) begin
            d0 = n_drop;
            w0 = n_wr;
            i_mrs_master.rsp.delete();
            i_mrs_master.send('{8'h01 + i[7:0], 8'h06, 8'h00, 8'h12, 8'h00, 8'h00}, i == 0);
            n = 0;
            while (n_drop == d0 && n < WAIT) begin
                @(negedge clk_i);
                n++;
            end
            repeat (20 * BIT) @(negedge clk_i);
            check("drop count", d0 + 1, n_drop);
            check("silent reply", 0, i_mrs_master.rsp.size());
            check("no write", w0, n_wr);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        n_fail = 0;
        samples_checked = 0;
        n_wr = 0;
        n_drop = 0;
        cyc = 0;
        resetn_i = 1'b0;
        repeat (4) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        sc_write_single();
        sc_read();
        sc_diag_echo();
        sc_multi_write();
        sc_exceptions();
        sc_dropped();
        tally_and_finish();
    end
    task automatic sc_diag_echo();
        xact('{8'h01, 8'h07}, '{8'h01, 8'h07});
    endtask
endmodule

// [rtl/mrs_defines.vh]
`ifndef MRS_DEFINES_VH
`define MRS_DEFINES_VH
// Clock and line timing
`define MRS_CLK_HZ        200000000
`define MRS_BAUD_DEFAULT  57600
`define MRS_BIT_CYCLES    (`MRS_CLK_HZ / `MRS_BAUD_DEFAULT)
// Silent interval of 3.5 characters, 11 bits each, closes a frame
`define MRS_GAP_BITS      39
`define MRS_GAP_CYCLES    (`MRS_BIT_CYCLES * `MRS_GAP_BITS)
// Function codes
`define MRS_FC_RD_HOLD    8'h03
`define MRS_FC_RD_INPUT   8'h04
`define MRS_FC_WR_SINGLE  8'h06
`define MRS_FC_DIAG       8'h07
`define MRS_FC_WR_MULTI   8'h10
`define MRS_FC_EXC_FLAG   8'h80
// Exception codes
`define MRS_EX_FUNC       8'h01
`define MRS_EX_ADDR       8'h02
`define MRS_EX_VALUE      8'h03
`define MRS_EX_FAIL       8'h04
// Limits
`define MRS_MAX_QTY       16'h007D
`define MRS_FRAME_MAX     64
`define MRS_CRC_INIT      16'hFFFF
`define MRS_CRC_POLY      16'hA001
`endif

// [rtl/mrs_slave.v]
`timescale 1ns/100ps
`include "mrs_defines.vh"
module mrs_slave #(
    parameter [7:0]  NODE_ADDR = 8'h01,       // Slave node address
    parameter [15:0] MAP_BASE  = 16'h0000,    // First mapped register
    parameter [15:0] MAP_SIZE  = 16'h0100,    // Mapped registers
    parameter        BIT_CYCLES = `MRS_BIT_CYCLES, // Clocks per bit, 57600 bit/s
    parameter        GAP_CYCLES = BIT_CYCLES * `MRS_GAP_BITS
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        resetn_i,
    // Serial line
    input  wire        rx_i,
    output reg         tx_o,
    // Parameter store port
    output reg  [15:0] par_addr_o,
    output reg  [15:0] par_wdata_o,
    output reg         par_wr_o,
    input  wire [15:0] par_rdata_i,
    input  wire        par_wide_i,
    input  wire        par_err_i,
    // Status
    output reg         frame_drop_o
);
    localparam ST_RX   = 3'd0;   // Collecting bytes
    localparam ST_CHK  = 3'd1;   // Decode and validate
    localparam ST_EXEC = 3'd2;   // Per-register access
    localparam ST_CRC  = 3'd3;   // Append response CRC
    localparam ST_TX   = 3'd4;   // Send response
    localparam ST_CRCR = 3'd5;   // Checksum received frame

    reg        rx_m_r, rx_s_r;              // Line synchroniser
    reg  [7:0] buf_r [0:`MRS_FRAME_MAX-1];  // Frame buffer, shared rx/tx
    reg  [6:0] len_r;                       // Bytes received / to send
    reg  [6:0] idx_r;                       // Walk index
    reg  [2:0] st_r;
    reg [31:0] gap_r;                       // Silence counter
    reg [15:0] crc_r;
    reg [15:0] cnt_r;                       // Registers left
    reg  [7:0] exc_r;
    reg  [3:0] cbit_r;                      // CRC bit step
    reg        tx_go_r;
    wire [7:0] urx_data;
    wire       urx_valid, urx_idle, utx_busy, utx_line;
    wire [7:0] fc    = buf_r[1];
    wire [15:0] sadr = {buf_r[2], buf_r[3]};
    wire [15:0] qty  = {buf_r[4], buf_r[5]};
    wire [16:0] aend = {1'b0, sadr} + {1'b0, qty};
    wire       in_map = (sadr >= MAP_BASE) &&
                        (aend <= ({1'b0, MAP_BASE} + {1'b0, MAP_SIZE}));
    wire       fc_rd = (fc == `MRS_FC_RD_HOLD) || (fc == `MRS_FC_RD_INPUT);

    mrs_uart #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .rx_i       (rx_s_r),
        .tx_o       (utx_line),
        .rx_data_o  (urx_data),
        .rx_valid_o (urx_valid),
        .rx_idle_o  (urx_idle),
        .tx_data_i  (buf_r[idx_r[5:0]]),
        .tx_start_i (tx_go_r),
        .tx_busy_o  (utx_busy)
    );

    // Main sequencer; one buffer keeps area small at the cost of half duplex
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_m_r <= 1'b1;
            rx_s_r <= 1'b1;
            tx_o <= 1'b1;
            st_r <= ST_RX;
            len_r <= 7'h00;
            idx_r <= 7'h00;
            gap_r <= 32'h0000_0000;
            crc_r <= `MRS_CRC_INIT;
            cnt_r <= 16'h0000;
            exc_r <= 8'h00;
            cbit_r <= 4'h0;
            tx_go_r <= 1'b0;
            par_addr_o <= 16'h0000;
            par_wdata_o <= 16'h0000;
            par_wr_o <= 1'b0;
            frame_drop_o <= 1'b0;
        end else begin
            rx_m_r <= rx_i;
            rx_s_r <= rx_m_r;
            tx_o <= utx_line;
            tx_go_r <= 1'b0;
            par_wr_o <= 1'b0;
            frame_drop_o <= 1'b0;
            case (st_r)
                ST_RX: begin
                    if (urx_valid) begin
                        gap_r <= 32'h0000_0000;
                        if (len_r < `MRS_FRAME_MAX) begin
                            buf_r[len_r[5:0]] <= urx_data;
                            len_r <= len_r + 7'h01;
                        end
                    end else if (!urx_idle || len_r == 7'h00) begin
                        gap_r <= 32'h0000_0000;
                    end else if (gap_r >= GAP_CYCLES - 1) begin
                        // Silence ends the frame
                        st_r <= ST_CRCR;
                        idx_r <= 7'h00;
                        cbit_r <= 4'h0;
                        crc_r <= `MRS_CRC_INIT;
                    end else begin
                        gap_r <= gap_r + 32'h0000_0001;
                    end
                end
                ST_CRCR: begin
                    // Bit-serial CRC over whole frame incl. its CRC
                    if (idx_r == len_r) begin
                        if (crc_r == 16'h0000 && len_r >= 7'd4 &&
                            buf_r[0] == NODE_ADDR) begin
                            st_r <= ST_CHK;
                        end else begin
                            frame_drop_o <= 1'b1;
                            len_r <= 7'h00;
                            st_r <= ST_RX;
                        end
                    end else if (cbit_r == 4'h8) begin
                        cbit_r <= 4'h0;
                        idx_r <= idx_r + 7'h01;
                    end else begin
                        if (cbit_r == 4'h0) begin
                            crc_r <= crc16_step(crc_r ^ {8'h00, buf_r[idx_r[5:0]]});
                        end else begin
                            crc_r <= crc16_step(crc_r);
                        end
                        cbit_r <= cbit_r + 4'h1;
                    end
                end
                ST_CHK: begin
                    exc_r <= 8'h00;
                    idx_r <= 7'd2;
                    cnt_r <= qty;
                    st_r <= ST_EXEC;
                    par_addr_o <= sadr;
                    if (fc == 8'h00 || fc[7]) begin
                        exc_r <= `MRS_EX_FUNC;
                    end else if (fc == `MRS_FC_DIAG) begin
                        len_r <= len_r - 7'd2;
                        st_r <= ST_CRC;
                    end else if (fc_rd || fc == `MRS_FC_WR_MULTI) begin
                        if (len_r < 7'd8) begin
                            frame_drop_o <= 1'b1;
                            len_r <= 7'h00;
                            st_r <= ST_RX;
                        end else if (qty == 16'h0000 || qty > `MRS_MAX_QTY ||
                                     (fc_rd && qty > 16'h001D) || // Reply must fit buffer
                                     (!fc_rd && {9'h000, len_r} !=
                                      {qty[14:0], 1'b0} + 16'h0009)) begin
                            exc_r <= `MRS_EX_VALUE;
                        end else if (!in_map) begin
                            exc_r <= `MRS_EX_ADDR;
                        end else if (fc_rd) begin
                            idx_r <= 7'd3;
                            buf_r[2] <= {qty[6:0], 1'b0};
                        end else begin
                            idx_r <= 7'd7;
                        end
                    end else if (fc == `MRS_FC_WR_SINGLE) begin
                        cnt_r <= 16'h0001;
                        idx_r <= 7'd4;
                        if (len_r != 7'd8) begin
                            // Stale bytes would be written otherwise
                            frame_drop_o <= 1'b1;
                            len_r <= 7'h00;
                            st_r <= ST_RX;
                        end else if (sadr < MAP_BASE ||
                                     {1'b0, sadr} >= {1'b0, MAP_BASE} + {1'b0, MAP_SIZE}) begin
                            exc_r <= `MRS_EX_ADDR;
                        end
                    end else begin
                        exc_r <= `MRS_EX_FUNC;
                    end
                end
                ST_EXEC: begin
                    if (exc_r != 8'h00) begin
                        // Exception frame: addr, fc|0x80, code
                        buf_r[1] <= fc | `MRS_FC_EXC_FLAG;
                        buf_r[2] <= exc_r;
                        len_r <= 7'd3;
                        st_r <= ST_CRC;
                    end else if (cnt_r == 16'h0000) begin
                        len_r <= fc_rd ? idx_r : 7'd6;
                        st_r <= ST_CRC;
                    end else if (par_err_i) begin
                        exc_r <= `MRS_EX_FAIL;
                    end else if (fc == `MRS_FC_WR_SINGLE && par_wide_i) begin
                        exc_r <= `MRS_EX_FAIL;
                    end else if (fc_rd) begin
                        buf_r[idx_r[5:0]] <= par_rdata_i[15:8];
                        buf_r[idx_r[5:0] + 6'd1] <= par_rdata_i[7:0];
                        idx_r <= idx_r + 7'd2;
                        cnt_r <= cnt_r - 16'h0001;
                        par_addr_o <= par_addr_o + 16'h0001;
                    end else begin
                        par_wdata_o <= {buf_r[idx_r[5:0]], buf_r[idx_r[5:0] + 6'd1]};
                        par_wr_o <= 1'b1;
                        idx_r <= idx_r + 7'd2;
                        cnt_r <= cnt_r - 16'h0001;
                        if (par_wr_o) begin
                            par_addr_o <= par_addr_o + 16'h0001;
                        end
                    end
                end
                ST_CRC: begin
                    // Append CRC over response bytes
                    if (idx_r == len_r && cbit_r == 4'h0) begin
                        buf_r[len_r[5:0]] <= crc_r[7:0];
                        buf_r[len_r[5:0] + 6'd1] <= crc_r[15:8];
                        len_r <= len_r + 7'd2;
                        idx_r <= 7'h00;
                        st_r <= ST_TX;
                    end else if (cbit_r == 4'h8) begin
                        cbit_r <= 4'h0;
                        idx_r <= idx_r + 7'h01;
                    end else begin
                        if (cbit_r == 4'h0) begin
                            if (idx_r == 7'h00 || st_r != ST_CRC) begin
                                crc_r <= crc16_step(`MRS_CRC_INIT ^ {8'h00, buf_r[0]});
                            end else begin
                                crc_r <= crc16_step(crc_r ^ {8'h00, buf_r[idx_r[5:0]]});
                            end
                        end else begin
                            crc_r <= crc16_step(crc_r);
                        end
                        cbit_r <= cbit_r + 4'h1;
                    end
                end
                ST_TX: begin
                    if (!utx_busy && !tx_go_r) begin
                        if (idx_r == len_r) begin
                            len_r <= 7'h00;
                            gap_r <= 32'h0000_0000;
                            st_r <= ST_RX;
                        end else begin
                            tx_go_r <= 1'b1;
                        end
                    end
                    if (tx_go_r) begin
                        idx_r <= idx_r + 7'h01;
                    end
                end
                default: st_r <= ST_RX;
            endcase
            if (st_r == ST_EXEC && exc_r == 8'h00 && cnt_r == 16'h0000) begin
                idx_r <= 7'h00;
                cbit_r <= 4'h0;
            end
            if (st_r == ST_EXEC && exc_r != 8'h00) begin
                idx_r <= 7'h00;
                cbit_r <= 4'h0;
            end
            if (st_r == ST_CHK && fc == `MRS_FC_DIAG) begin
                idx_r <= 7'h00;
                cbit_r <= 4'h0;
            end
        end
    end

    // One CRC-16 shift step, reflected polynomial
    function [15:0] crc16_step;
        input [15:0] c;
        begin
            crc16_step = c[0] ? ((c >> 1) ^ `MRS_CRC_POLY) : (c >> 1);
        end
    endfunction
endmodule

// [rtl/mrs_uart.v]
`timescale 1ns/100ps
`include "mrs_defines.vh"
// Byte serialiser/deserialiser, 8N1, fixed bit period
module mrs_uart #(
    parameter BIT_CYCLES = `MRS_BIT_CYCLES
) (
    // Clock and reset
    input  wire       clk_i,
    input  wire       resetn_i,
    // Line, rx already synchronised
    input  wire       rx_i,
    output reg        tx_o,
    // Receive side
    output reg  [7:0] rx_data_o,
    output reg        rx_valid_o,
    output reg        rx_idle_o,
    // Transmit side
    input  wire [7:0] tx_data_i,
    input  wire       tx_start_i,
    output reg        tx_busy_o
);
    reg [15:0] rx_cnt_r;     // Rx bit timer
    reg [3:0]  rx_bit_r;     // Rx bit index
    reg [8:0]  rx_sh_r;      // Rx shifter
    reg        rx_act_r;     // Rx in a character
    reg [15:0] tx_cnt_r;     // Tx bit timer
    reg [3:0]  tx_bit_r;     // Tx bit index
    reg [9:0]  tx_sh_r;      // Tx shifter with start/stop

    // Receiver: mid-bit sampling after start edge
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_cnt_r   <= 16'h0000;
            rx_bit_r   <= 4'h0;
            rx_sh_r    <= 9'h000;
            rx_act_r   <= 1'b0;
            rx_data_o  <= 8'h00;
            rx_valid_o <= 1'b0;
            rx_idle_o  <= 1'b1;
        end else begin
            rx_valid_o <= 1'b0;
            rx_idle_o  <= !rx_act_r;
            if (!rx_act_r) begin
                if (!rx_i) begin
                    // Start at half period to hit bit centres
                    rx_act_r <= 1'b1;
                    rx_cnt_r <= BIT_CYCLES[15:0] >> 1;
                    rx_bit_r <= 4'h0;
                end
            end else if (rx_cnt_r != 16'h0000) begin
                rx_cnt_r <= rx_cnt_r - 16'h0001;
            end else begin
                rx_cnt_r <= BIT_CYCLES[15:0] - 16'h0001;
                rx_sh_r  <= {rx_i, rx_sh_r[8:1]};
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == 4'h0 && rx_i) begin
                    rx_act_r <= 1'b0;   // Glitch, not a start bit
                end else if (rx_bit_r == 4'h9) begin
                    rx_act_r   <= 1'b0;
                    rx_data_o  <= rx_sh_r[8:1];
                    rx_valid_o <= rx_i; // Framing error drops the byte
                end
            end
        end
    end

    // Transmitter: LSB first, one stop bit
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_cnt_r  <= 16'h0000;
            tx_bit_r  <= 4'h0;
            tx_sh_r   <= 10'h3FF;
            tx_o      <= 1'b1;
            tx_busy_o <= 1'b0;
        end else if (!tx_busy_o) begin
            tx_o <= 1'b1;
            if (tx_start_i) begin
                tx_sh_r   <= {1'b1, tx_data_i, 1'b0};
                tx_busy_o <= 1'b1;
                tx_bit_r  <= 4'h0;
                tx_cnt_r  <= 16'h0000;
            end
        end else if (tx_cnt_r != 16'h0000) begin
            tx_cnt_r <= tx_cnt_r - 16'h0001;
        end else if (tx_bit_r == 4'hA) begin
            tx_busy_o <= 1'b0;
        end else begin
            tx_o     <= tx_sh_r[0];
            tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            tx_cnt_r <= BIT_CYCLES[15:0] - 16'h0001;
        end
    end
endmodule
